// file: hdl/acs_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// Register byte offsets
`define ACS_OFF_CONTROL_ONE   8'h00
`define ACS_OFF_CONTROL_THREE 8'h04
`define ACS_OFF_RESULT        8'h08
`define ACS_OFF_STATUS        8'h0C

// Control one field positions
`define ACS_C1_CONVERTER_ON   15
`define ACS_C1_IDLE_STOP      13
`define ACS_C1_BUFFER_MODE    12
`define ACS_C1_EXT_DMA_EN     11
`define ACS_C1_TWELVE_BIT     10
`define ACS_C1_FORMAT_HI      9
`define ACS_C1_FORMAT_LO      8
`define ACS_C1_SOURCE_HI      7
`define ACS_C1_SOURCE_LO      4
`define ACS_C1_AUTO_SAMPLE    2
`define ACS_C1_SAMPLE         1
`define ACS_C1_DONE           0

// Control three field positions
`define ACS_C3_PUMP_EN        13
`define ACS_C3_SAMPLE_TIME_HI 12
`define ACS_C3_SAMPLE_TIME_LO 8
`define ACS_C3_DIVIDER_HI     7
`define ACS_C3_DIVIDER_LO     0

// Reset values
`define ACS_RST_CONTROL_ONE   16'h0000
`define ACS_RST_CONTROL_THREE 16'h0000

// Sample clock source codes
`define ACS_SRC_SOFTWARE      4'h0
`define ACS_SRC_EXT_INT_ZERO  4'h1
`define ACS_SRC_TIMER_THREE   4'h2
`define ACS_SRC_CHARGE_TIME   4'h4
`define ACS_SRC_TIMER_ONE     4'h5
`define ACS_SRC_TIMER_ONE_SLP 4'h6
`define ACS_SRC_AUTO_CONVERT  4'h7

// Output format codes
`define ACS_FMT_UINT          2'h0
`define ACS_FMT_SINT          2'h1
`define ACS_FMT_UFRAC         2'h2
`define ACS_FMT_SFRAC         2'h3

// Converter clock period counts
`define ACS_SAR_TAD_TEN       4'hC
`define ACS_SAR_TAD_TWELVE    4'hE
`define ACS_SYNC_TAD          4'h2

`endif

// file: hdl/acs_pkg.sv
// Types shared by the converter control sequencer.
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_ST_IDLE,
    ACS_ST_CONVERT,
    ACS_ST_SYNC
  } acs_state_type;

endpackage : acs_pkg

// file: hdl/acs_sequencer.sv
// Converter control sequencer with APB register access.
//
// Overview of operation
// (R1) Converter runs only while converter_on is one; off otherwise.
// (R2) With idle_stop set, converter activity halts while the system idles.
// (R3) Extended DMA and buffer features work only while extended_dma_enable.
// (R4) Buffer mode one uses DMA destination addressing, zero indirect mode.
// (R5) Buffer mode bit is stored and effective only with extended DMA on.
// (R6) twelve_bit_select one gives 12-bit conversions, zero gives 10-bit.
// (R7) Two-bit output_format selects signed/unsigned, left/right justified.
// (R8) Four-bit sample_clock_source picks what ends sampling and starts conversion.
// (R9) auto_sample_start resamples after each conversion, setting sample_control.
// (R10) Hardware sets/clears sample and done; software only clears done.
// (R11) Unimplemented control one bits 14 and 3 read as zero.
// (R12) Converter period is an eight-bit programmable multiple of instruction cycle.
// (R13) Sample, conversion and sync phases all count converter periods.
// (R14) Conversion takes 12 periods in 10-bit mode, 14 in 12-bit.
// (R15) Synchronisation adds between 1.5 and 2.5 periods per conversion.
// (R16) A cycle is sample period, then conversion, then synchronisation.
// (R17) Software keeps divider at two cycles or more with the RC clock.
// (R18) Software sets charge_pump_enable when the analog supply is low.
// (R19) Sample-and-hold samples while sample_control is one, holds otherwise.
// (R20) Done sets at cycle completion and reads zero while converting.
// (R21) Divider code 0 gives one cycle per period, 255 gives 256.
// (R22) auto_sample_time gives 0 to 31 converter periods of sampling.
// (R23) Sample fall starts conversion; completion sets done and maybe resamples.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "acs_map.svh"

module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System power state, same clock
  input  wire logic        system_idle,
  input  wire logic        system_sleep,
  // Trigger sources
  input  wire logic        external_interrupt_zero,
  input  wire logic        timer_three_trigger,
  input  wire logic        timer_one_trigger,
  input  wire logic        charge_time_unit_trigger,
  // Successive-approximation front end
  input  wire logic [11:0] sar_raw_result,
  output logic             converter_enable,
  output logic             sample_hold_sample,
  output logic             sar_converting,
  output logic             twelve_bit_mode,
  output logic             charge_pump_enable,
  // Result and DMA side
  output logic      [15:0] conversion_result,
  output logic             conversion_done,
  output logic             dma_request,
  output logic             dma_extended_buffer,
  output logic             dma_indirect_mode
);

  logic            converter_on_q;
  logic            idle_stop_q;
  logic            dma_buffer_mode_select_q;
  logic            extended_dma_enable_q;
  logic            twelve_bit_select_q;
  logic [1:0]      output_format_q;
  logic [3:0]      sample_clock_source_q;
  logic            auto_sample_start_q;
  logic            sample_control_q;
  logic            done_q;
  logic            charge_pump_enable_q;
  logic [4:0]      auto_sample_time_q;
  logic [7:0]      conversion_clock_divider_q;

  acs_state_type   state_q;
  logic [7:0]      tad_cnt_q;
  logic [4:0]      smp_cnt_q;
  logic [3:0]      phase_cnt_q;
  logic            sample_prev_q;
  logic [15:0]     result_q;
  logic            done_pulse_q;
  logic            dma_req_q;
  logic [2:0]      ext_int_sync_q;
  logic            ext_int_level_q;

  logic [31:0]     prdata_q;
  logic            pready_q;
  logic            pslverr_q;

  logic            run;
  logic            tad_tick;
  logic            apb_done;
  logic            wr_one;
  logic            wr_three;
  logic            addr_hit;
  logic            ext_int_rise;
  logic            trigger;
  logic            auto_end;
  logic            conv_start;
  logic            conv_finish;
  logic [3:0]      sar_len;
  logic [15:0]     ctl_one_rd;
  logic [15:0]     ctl_three_rd;
  logic [31:0]     rd_mux;

  // Converter runs only when on and not stopped by idle
  assign run = converter_on_q
               && !(idle_stop_q && system_idle); // (R1) (R2)

  // Converter period tick: divider code plus one instruction cycles
  assign tad_tick = run
                    && (tad_cnt_q == conversion_clock_divider_q); // (R12) (R21)

  assign sar_len = twelve_bit_select_q ? `ACS_SAR_TAD_TWELVE
                                       : `ACS_SAR_TAD_TEN; // (R6) (R14)

  // A completed APB access; writes land only on this edge
  assign apb_done = psel && penable && pready_q;
  assign wr_one   = apb_done && pwrite && (paddr == `ACS_OFF_CONTROL_ONE);
  assign wr_three = apb_done && pwrite && (paddr == `ACS_OFF_CONTROL_THREE);
  assign addr_hit = (paddr == `ACS_OFF_CONTROL_ONE)
                    || (paddr == `ACS_OFF_CONTROL_THREE)
                    || (paddr == `ACS_OFF_RESULT)
                    || (paddr == `ACS_OFF_STATUS);

  // Pin edge counts once the second and third stages agree
  assign ext_int_rise = (ext_int_sync_q[1] == ext_int_sync_q[2])
                        && ext_int_sync_q[2] && !ext_int_level_q;

  always_comb begin
    unique case (sample_clock_source_q)
      `ACS_SRC_EXT_INT_ZERO:  trigger = ext_int_rise;
      `ACS_SRC_TIMER_THREE:   trigger = timer_three_trigger;
      `ACS_SRC_CHARGE_TIME:   trigger = charge_time_unit_trigger;
      `ACS_SRC_TIMER_ONE:     trigger = timer_one_trigger && !system_sleep;
      `ACS_SRC_TIMER_ONE_SLP: trigger = timer_one_trigger;
      default:                trigger = 1'b0;
    endcase
  end // (R8)

  assign auto_end = (sample_clock_source_q == `ACS_SRC_AUTO_CONVERT)
                    && sample_control_q && tad_tick
                    && (smp_cnt_q == auto_sample_time_q); // (R22) (R13)

  // Falling sample bit starts the conversion phase
  assign conv_start  = run && (state_q == ACS_ST_IDLE)
                       && sample_prev_q && !sample_control_q; // (R23) (R16)
  assign conv_finish = (state_q == ACS_ST_SYNC) && tad_tick
                       && (phase_cnt_q == `ACS_SYNC_TAD - 4'h1); // (R15)

  function automatic logic [15:0] acs_format(
    input logic [11:0] raw,
    input logic        twelve,
    input logic [1:0]  fmt
  );
    logic [11:0] code;
    logic [11:0] sgn;
    logic [15:0] res;
    code = twelve ? raw : {2'h0, raw[9:0]};
    sgn  = twelve ? {~raw[11], raw[10:0]} : {2'h0, ~raw[9], raw[8:0]};
    res  = 16'h0000;
    unique case (fmt)
      `ACS_FMT_UINT: res = {4'h0, code};
      `ACS_FMT_SINT:  res = twelve ? {{4{sgn[11]}}, sgn}
                                   : {{6{sgn[9]}}, sgn[9:0]};
      `ACS_FMT_UFRAC: res = twelve ? {code, 4'h0} : {code[9:0], 6'h00};
      `ACS_FMT_SFRAC: res = twelve ? {sgn, 4'h0} : {sgn[9:0], 6'h00};
    endcase
    return res;
  endfunction : acs_format

  // Register read images; unimplemented bits stay zero
  always_comb begin
    ctl_one_rd = 16'h0000; // (R11)
    ctl_one_rd[`ACS_C1_CONVERTER_ON] = converter_on_q;
    ctl_one_rd[`ACS_C1_IDLE_STOP]    = idle_stop_q;
    ctl_one_rd[`ACS_C1_BUFFER_MODE]  = dma_buffer_mode_select_q
                                       && extended_dma_enable_q; // (R5)
    ctl_one_rd[`ACS_C1_EXT_DMA_EN]   = extended_dma_enable_q;
    ctl_one_rd[`ACS_C1_TWELVE_BIT]   = twelve_bit_select_q;
    ctl_one_rd[`ACS_C1_FORMAT_HI:`ACS_C1_FORMAT_LO] = output_format_q;
    ctl_one_rd[`ACS_C1_SOURCE_HI:`ACS_C1_SOURCE_LO] = sample_clock_source_q;
    ctl_one_rd[`ACS_C1_AUTO_SAMPLE]  = auto_sample_start_q;
    ctl_one_rd[`ACS_C1_SAMPLE]       = sample_control_q;
    ctl_one_rd[`ACS_C1_DONE]         = done_q;
    ctl_three_rd = 16'h0000;
    ctl_three_rd[`ACS_C3_PUMP_EN]    = charge_pump_enable_q;
    ctl_three_rd[`ACS_C3_SAMPLE_TIME_HI:`ACS_C3_SAMPLE_TIME_LO] =
      auto_sample_time_q;
    ctl_three_rd[`ACS_C3_DIVIDER_HI:`ACS_C3_DIVIDER_LO] =
      conversion_clock_divider_q;
    unique case (paddr)
      `ACS_OFF_CONTROL_ONE:   rd_mux = {16'h0000, ctl_one_rd};
      `ACS_OFF_CONTROL_THREE: rd_mux = {16'h0000, ctl_three_rd};
      `ACS_OFF_RESULT:        rd_mux = {16'h0000, result_q};
      `ACS_OFF_STATUS:        rd_mux = {30'h00000000, state_q};
      default:                rd_mux = 32'h00000000;
    endcase
  end

  // APB answer: one wait state, so data and ready leave flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q  <= 1'b1;
      prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_q <= !addr_hit;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on_q             <= 1'b0;
      idle_stop_q                <= 1'b0;
      dma_buffer_mode_select_q   <= 1'b0;
      extended_dma_enable_q      <= 1'b0;
      twelve_bit_select_q        <= 1'b0;
      output_format_q            <= 2'h0;
      sample_clock_source_q      <= 4'h0;
      auto_sample_start_q        <= 1'b0;
    end else if (wr_one && !pslverr_q) begin
      converter_on_q             <= pwdata[`ACS_C1_CONVERTER_ON];
      idle_stop_q                <= pwdata[`ACS_C1_IDLE_STOP];
      // Mode bit only accepted alongside extended DMA enable
      dma_buffer_mode_select_q   <= pwdata[`ACS_C1_BUFFER_MODE]
                                    && pwdata[`ACS_C1_EXT_DMA_EN]; // (R5)
      extended_dma_enable_q      <= pwdata[`ACS_C1_EXT_DMA_EN];
      twelve_bit_select_q        <= pwdata[`ACS_C1_TWELVE_BIT];
      output_format_q            <= pwdata[`ACS_C1_FORMAT_HI:`ACS_C1_FORMAT_LO];
      sample_clock_source_q      <= pwdata[`ACS_C1_SOURCE_HI:`ACS_C1_SOURCE_LO];
      auto_sample_start_q        <= pwdata[`ACS_C1_AUTO_SAMPLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_pump_enable_q       <= 1'b0;
      auto_sample_time_q         <= 5'h00;
      conversion_clock_divider_q <= 8'h00;
    end else if (wr_three) begin
      charge_pump_enable_q       <= pwdata[`ACS_C3_PUMP_EN];
      auto_sample_time_q         <=
        pwdata[`ACS_C3_SAMPLE_TIME_HI:`ACS_C3_SAMPLE_TIME_LO];
      conversion_clock_divider_q <=
        pwdata[`ACS_C3_DIVIDER_HI:`ACS_C3_DIVIDER_LO];
    end
  end

  // Sample bit: software writes it, hardware events take priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_control_q <= 1'b0;
    end else if (!converter_on_q) begin
      sample_control_q <= 1'b0; // (R1)
    end else if (conv_finish && auto_sample_start_q) begin
      sample_control_q <= 1'b1; // (R9) (R23) (R10)
    end else if (run && sample_control_q && (trigger || auto_end)) begin
      sample_control_q <= 1'b0; // (R8) (R10)
    end else if (wr_one) begin
      sample_control_q <= pwdata[`ACS_C1_SAMPLE];
    end
  end

  // Done bit: set wins over a software clear; software writes of one ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (conv_finish) begin
      done_q <= 1'b1; // (R20) (R23)
    end else if (conv_start) begin
      done_q <= 1'b0; // (R20)
    end else if (wr_one && !pwdata[`ACS_C1_DONE]) begin
      done_q <= 1'b0; // (R10)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tad_cnt_q <= 8'h00;
    end else if (!run || tad_tick) begin
      tad_cnt_q <= 8'h00; // (R12)
    end else begin
      tad_cnt_q <= tad_cnt_q + 8'h01;
    end
  end

  // Auto-sample period counter restarts whenever sampling is not active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_cnt_q <= 5'h00;
    end else if (!sample_control_q) begin
      smp_cnt_q <= 5'h00;
    end else if (tad_tick && (smp_cnt_q != auto_sample_time_q)) begin
      smp_cnt_q <= smp_cnt_q + 5'h01; // (R22)
    end
  end

  // Pin synchroniser; only stages two and three are examined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_int_sync_q  <= 3'h0;
      ext_int_level_q <= 1'b0;
    end else begin
      ext_int_sync_q  <= {ext_int_sync_q[1:0], external_interrupt_zero};
      if (ext_int_sync_q[1] == ext_int_sync_q[2]) begin
        ext_int_level_q <= ext_int_sync_q[2];
      end
    end
  end

  // Conversion sequence; sync uses a fixed 2 periods, inside the 1.5..2.5 span
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= ACS_ST_IDLE;
      phase_cnt_q   <= 4'h0;
      sample_prev_q <= 1'b0;
    end else if (!converter_on_q) begin
      state_q       <= ACS_ST_IDLE; // (R1)
      phase_cnt_q   <= 4'h0;
      sample_prev_q <= 1'b0;
    end else if (run) begin
      sample_prev_q <= sample_control_q;
      unique case (state_q)
        ACS_ST_IDLE: begin
          if (conv_start) begin
            state_q     <= ACS_ST_CONVERT; // (R23)
            phase_cnt_q <= 4'h0;
          end
        end
        ACS_ST_CONVERT: begin
          if (tad_tick) begin
            if (phase_cnt_q == sar_len - 4'h1) begin
              state_q     <= ACS_ST_SYNC; // (R14) (R16)
              phase_cnt_q <= 4'h0;
            end else begin
              phase_cnt_q <= phase_cnt_q + 4'h1; // (R13)
            end
          end
        end
        ACS_ST_SYNC: begin
          if (conv_finish) begin
            state_q     <= ACS_ST_IDLE; // (R15)
            phase_cnt_q <= 4'h0;
          end else if (tad_tick) begin
            phase_cnt_q <= phase_cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= ACS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q     <= 16'h0000;
      done_pulse_q <= 1'b0;
      dma_req_q    <= 1'b0;
    end else begin
      done_pulse_q <= conv_finish;
      dma_req_q    <= conv_finish && extended_dma_enable_q; // (R3)
      if (conv_finish) begin
        result_q <= acs_format(sar_raw_result, twelve_bit_select_q,
                               output_format_q); // (R7) (R6)
      end
    end
  end

  logic conv_en_q;
  logic conv_busy_q;
  logic ext_buf_q;
  logic pia_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_en_q   <= 1'b0;
      conv_busy_q <= 1'b0;
      ext_buf_q   <= 1'b0;
      pia_q       <= 1'b0;
    end else begin
      conv_en_q   <= run; // (R1) (R2)
      conv_busy_q <= (state_q == ACS_ST_CONVERT);
      ext_buf_q   <= extended_dma_enable_q
                     && dma_buffer_mode_select_q; // (R4) (R3)
      pia_q       <= extended_dma_enable_q
                     && !dma_buffer_mode_select_q; // (R4) (R3)
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign converter_enable    = conv_en_q;
  assign sample_hold_sample  = sample_control_q; // (R19)
  assign sar_converting      = conv_busy_q;
  assign twelve_bit_mode     = twelve_bit_select_q;
  assign charge_pump_enable  = charge_pump_enable_q;
  assign conversion_result   = result_q;
  assign conversion_done     = done_pulse_q;
  assign dma_request         = dma_req_q;
  assign dma_extended_buffer = ext_buf_q;
  assign dma_indirect_mode   = pia_q;

endmodule : acs_sequencer

// file: verif/acs_sequencer_chk.sv
// Port-level assertions for the converter control sequencer.
`timescale 1ns/10ps
module acs_sequencer_chk (
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter side
  input wire logic        system_idle,
  input wire logic        converter_enable,
  input wire logic        sample_hold_sample,
  input wire logic        sar_converting,
  input wire logic        twelve_bit_mode,
  input wire logic        conversion_done,
  input wire logic        dma_request
);
  logic [15:0] c1_q;
  logic [7:0]  div_q;
  logic [11:0] run_q;
  logic [11:0] hi;
  logic        wr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr = psel & penable & pready & pwrite;
  // Assumes the divider is not rewritten in mid-conversion
  assign hi = (twelve_bit_mode ? 12'h00E : 12'h00C) * ({4'h0, div_q} + 12'h001);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c1_q <= 16'h0000;
    else if (wr && paddr == 8'h00) c1_q <= pwdata[15:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 8'h00;
    else if (wr && paddr == 8'h04) div_q <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 12'h000;
    else run_q <= sar_converting ? run_q + 12'h001 : 12'h000;
  end
  on_idle_a: assert property (converter_enable ==
    $past(c1_q[15] & ~(c1_q[13] & system_idle))) else $error("enable wrong");
  mode_sel_a: assert property (twelve_bit_mode == c1_q[10])
    else $error("mode bit wrong");
  conv_len_a: assert property ($fell(sar_converting) |->
    run_q <= hi && run_q >= hi - {4'h0, div_q}) else $error("conv length");
  busy_done_a: assert property (sar_converting |-> !conversion_done)
    else $error("done while busy");
  sync_end_a: assert property ($fell(sar_converting) && converter_enable
    |-> ##[1:600] conversion_done) else $error("no completion");
  conv_start_a: assert property ($fell(sample_hold_sample) && c1_q[15]
    |-> ##[1:2] sar_converting) else $error("no conversion");
  auto_sample_control_a: assert property (conversion_done |->
    sample_hold_sample == c1_q[2]) else $error("resample wrong");
  dma_gate_a: assert property (conversion_done |-> dma_request == c1_q[11])
    else $error("dma gate");
  dma_only_a: assert property (dma_request |-> conversion_done)
    else $error("stray dma request");
  zero_bits_a: assert property (pready && !pwrite && paddr == 8'h00
    |-> !prdata[14] && !prdata[3]) else $error("reserved bit set");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  ready_once_a: assert property (pready |=> !pready) else $error("long ready");
  cover property (conversion_done && twelve_bit_mode);
  cover property (dma_request);
  cover property (pready && pslverr);
endmodule : acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk i_acs_sequencer_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .system_idle, .converter_enable, .sample_hold_sample, .sar_converting,
  .twelve_bit_mode, .conversion_done, .dma_request);

// file: verif/acs_front_end.sv
// Behavioural sample-and-hold front end and DMA request counter.
`timescale 1ns/10ps
module acs_front_end (
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // From the sequencer
  input wire logic         sample_hold_sample,
  input wire logic         conversion_done,
  input wire logic         dma_request,
  // To the sequencer and bench
  output logic      [11:0] sar_raw_result,
  output logic      [11:0] code,
  output logic      [7:0]  dma_count
);
  logic prev_q;
  logic hold_q;
  // Outside a hold the code is inverted so a stale read shows up
  assign sar_raw_result = hold_q ? code : ~code;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      hold_q <= 1'b0;
      code <= 12'h5A3;
      dma_count <= 8'h00;
    end else begin
      prev_q <= sample_hold_sample;
      if (sample_hold_sample && !prev_q) code <= code + 12'h2B7;
      if (!sample_hold_sample && prev_q) hold_q <= 1'b1;
      else if (conversion_done) hold_q <= 1'b0;
      if (dma_request) dma_count <= dma_count + 8'h01;
    end
  end
endmodule : acs_front_end

// file: verif/adc_control_sequencer_tb_top.sv
// Self-checking testbench for the converter control sequencer.
`timescale 1ns/10ps
`define CHK(g, e) begin logic [32:0] cv; cv = (e); total_checks++; \
  if ((g) !== cv) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, cv); end end
module adc_control_sequencer_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic system_idle = 0, system_sleep = 0, external_interrupt_zero = 0;
  logic timer_three_trigger = 0, timer_one_trigger = 0;
  logic charge_time_unit_trigger = 0;
  logic [31:0] prdata;
  logic pready, pslverr, converter_enable, sample_hold_sample, sar_converting;
  logic twelve_bit_mode, charge_pump_enable, conversion_done, dma_request;
  logic dma_extended_buffer, dma_indirect_mode;
  logic [15:0] conversion_result, cfg, c3;
  logic [11:0] sar_raw_result, code;
  logic [7:0] dma_count, d;
  logic [32:0] rd_q[$];
  logic [15:0] res_q[$];
  logic [3:0] srcs[8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0};
  logic [31:0] r;
  logic [1:0] f;
  logic m, ext, auto_sample_start, bm;
  int mismatches = 0, total_checks = 0, seed = 32'hF03C, cnt, base;
  acs_sequencer i_acs_sequencer (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .system_idle, .system_sleep,
    .external_interrupt_zero, .timer_three_trigger, .timer_one_trigger,
    .charge_time_unit_trigger, .sar_raw_result, .converter_enable,
    .sample_hold_sample, .sar_converting, .twelve_bit_mode,
    .charge_pump_enable, .conversion_result, .conversion_done, .dma_request,
    .dma_extended_buffer, .dma_indirect_mode);
  acs_front_end i_acs_front_end (.pclk, .presetn, .sample_hold_sample,
    .conversion_done, .dma_request, .sar_raw_result, .code, .dma_count);
  always #12.5 pclk = ~pclk;
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, a, {16'h0000, v});
  endtask : wr
  task rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task pulse(input logic [3:0] t);
    @(posedge pclk);
    {charge_time_unit_trigger, timer_one_trigger, timer_three_trigger,
      external_interrupt_zero} <= t;
    repeat (2) @(posedge pclk);
    {charge_time_unit_trigger, timer_one_trigger, timer_three_trigger,
      external_interrupt_zero} <= 4'h0;
  endtask : pulse
  function automatic logic [3:0] sel(input logic [3:0] s);
    case (s)
      4'h1: return 4'h1;
      4'h2: return 4'h2;
      4'h4: return 4'h8;
      4'h5, 4'h6: return 4'h4;
      default: return 4'h0;
    endcase
  endfunction : sel
  // Offset binary turns signed by inverting the top code bit
  function automatic logic [15:0] fmt_exp(input logic [11:0] c, input logic t,
                                          input logic [1:0] q);
    case (q)
      2'h0: return t ? {4'h0, c} : {6'h00, c[9:0]};
      2'h1: return t ? {{5{~c[11]}}, c[10:0]} : {{7{~c[9]}}, c[8:0]};
      2'h2: return t ? {c, 4'h0} : {c[9:0], 6'h00};
      default: return t ? {~c[11], c[10:0], 4'h0} : {~c[9], c[8:0], 6'h00};
    endcase
  endfunction : fmt_exp
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      `CHK({pslverr, prdata}, rd_q.pop_front())
    end
    if (conversion_done === 1'b1) `CHK(conversion_result, res_q.pop_front())
  end
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h10, {1'b1, 32'h0}); // Unmapped place answers with an error
    wr(8'h00, 16'h7F0C);
    rd(8'h00, {17'h0, 16'h3F04});
    `CHK(dma_extended_buffer, 1'b1)
    wr(8'h00, 16'h1000);
    rd(8'h00, 33'h0);
    `CHK(dma_extended_buffer, 1'b0)
    wr(8'h00, 16'hA000);
    repeat (3) @(posedge pclk);
    `CHK(converter_enable, 1'b1)
    system_idle <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(converter_enable, 1'b0)
    wr(8'h00, 16'h8000);
    repeat (3) @(posedge pclk);
    `CHK(converter_enable, 1'b1)
    system_idle <= 1'b0;
    wr(8'h00, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      f = i[1:0]; m = i[2]; ext = i[0]; bm = (i == 3); auto_sample_start = (i == 7);
      r = $random(seed);
      d = {6'h00, r[1:0]};
      c3 = {2'b00, r[4], 5'h04, d};
      wr(8'h04, c3);
      rd(8'h04, {17'h0, c3});
      `CHK(charge_pump_enable, r[4])
      cfg = {1'b1, 2'b00, bm, ext, m, f, srcs[i], 1'b0, auto_sample_start, 2'b00};
      wr(8'h00, cfg);
      wr(8'h00, cfg | 16'h0002);
      repeat (2) @(posedge pclk);
      res_q.push_back(fmt_exp(code, m, f));
      if (srcs[i] != 4'h7) begin
        system_sleep <= (srcs[i] == 4'h5);
        pulse(srcs[i] == 4'h5 ? 4'h4 : ~sel(srcs[i]));
        repeat (8) @(posedge pclk);
        `CHK(sample_hold_sample, 1'b1)
        system_sleep <= (srcs[i] == 4'h6);
        if (srcs[i] == 4'h0) wr(8'h00, cfg);
        else pulse(sel(srcs[i]));
      end
      while (sample_hold_sample !== 1'b0) @(posedge pclk);
      for (cnt = 0; conversion_done !== 1'b1; cnt++) @(posedge pclk);
      base = ((m ? 14 : 12) + 2) * (d + 1);
      `CHK(cnt >= base - d + 1 && cnt <= base + 1, 1'b1)
      `CHK(sample_hold_sample, auto_sample_start)
      `CHK(dma_indirect_mode, ext & ~bm)
      system_sleep <= 1'b0;
      rd(8'h00, {17'h0, cfg | 16'h0001 | {auto_sample_start, 1'b0}});
      wr(8'h00, 16'h0000);
    end
    `CHK(dma_count, 8'h04)
    end_of_test();
  end
endmodule : adc_control_sequencer_tb_top
